// ==== include/ccrb_pkg.sv ====
`default_nettype none

package ccrb_pkg;

   // ----------------------------------------------------------------
   // Bus geometry
   // ----------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int STRB_W = DATA_W / 8;

   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] SYSTEM_CONTROL_OFS    = 8'h00;
   localparam logic [ADDR_W-1:0] SPARE_CONTROL_OFS     = 8'h04;
   localparam logic [ADDR_W-1:0] FAULT_ADDRESS_OFS     = 8'h08;
   localparam logic [ADDR_W-1:0] PAGE_BASE_OFS         = 8'h0c;
   localparam logic [ADDR_W-1:0] TIMESTAMP_CONTROL_OFS = 8'h10;

   // ----------------------------------------------------------------
   // System control register fields
   // ----------------------------------------------------------------
   localparam int PAGING_ENABLE_BIT         = 31;
   localparam int CACHE_DISABLE_BIT         = 30;
   localparam int WRITE_BACK_SELECT_BIT     = 29;
   localparam int ALIGNMENT_CHECK_MASK_BIT  = 18;
   localparam int WRITE_PROTECT_BIT         = 16;
   localparam int TASK_SWITCHED_BIT         = 3;
   localparam int EMULATE_COPROC_BIT        = 2;
   localparam int MONITOR_COPROC_BIT        = 1;
   localparam int PROTECTED_MODE_ENABLE_BIT = 0;
   localparam logic [DATA_W-1:0] SYSTEM_CONTROL_MASK  = 32'he005000f;
   localparam logic [DATA_W-1:0] SYSTEM_CONTROL_RESET = 32'h00000000;

   // ----------------------------------------------------------------
   // Fault address, page base and timestamp control fields
   // ----------------------------------------------------------------
   localparam logic [DATA_W-1:0] FAULT_ADDRESS_RESET = 32'h00000000;
   localparam int PAGE_DIR_BASE_LSB = 12;
   localparam int PAGE_DIR_BASE_W   = DATA_W - PAGE_DIR_BASE_LSB;
   localparam logic [PAGE_DIR_BASE_W-1:0] PAGE_DIR_BASE_RESET = 20'h00000;
   localparam int TS_PRIV_LOCK_BIT = 2;
   localparam logic TS_PRIV_LOCK_RESET = 1'b1;

   // ----------------------------------------------------------------
   // Privilege and response codes
   // ----------------------------------------------------------------
   localparam int PRIV_W = 2;
   localparam logic [PRIV_W-1:0] MOST_PRIVILEGED = 2'h0;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [1:0] RESP_DECERR = 2'h3;
   localparam logic [DATA_W-1:0] ZERO_WORD = 32'h00000000;

   typedef enum logic [0:0] {WR_COLLECT, WR_RESP} ccrb_wr_state_t;
   typedef enum logic [0:0] {RD_IDLE, RD_RESP} ccrb_rd_state_t;

endpackage

`default_nettype wire

// ==== src/ccrb_ts_gate.sv ====
`timescale 1ns/1ps
`default_nettype none

module ccrb_ts_gate (
   input  wire logic                        clk,
   input  wire logic                        rst,
   input  wire logic                        lock,
   input  wire logic [ccrb_pkg::PRIV_W-1:0] priv_level,
   input  wire logic                        req,
   output var  logic                        grant,
   output var  logic                        fault
);

   // ----------------------------------------------------------------
   // Permission decision
   // ----------------------------------------------------------------
   logic next_grant;
   logic next_fault;
   logic allowed;

   always_comb begin
      // An unlocked counter is open to every level, a locked one only
      // to the most privileged level.
      allowed = !lock || (priv_level == ccrb_pkg::MOST_PRIVILEGED);
      next_grant = req && allowed;
      next_fault = req && !allowed;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         grant <= 1'b0;
         fault <= 1'b0;
      end else begin
         grant <= next_grant;
         fault <= next_fault;
      end
   end

endmodule

`default_nettype wire

// ==== src/ccrb_regs.sv ====
// The implementer's own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none

module ccrb_regs (
   input  wire logic                                  SYS_CLK,
   input  wire logic                                  RST,
   input  wire logic [ccrb_pkg::ADDR_W-1:0]           S_AXI_AWADDR,
   input  wire logic                                  S_AXI_AWVALID,
   output var  logic                                  S_AXI_AWREADY,
   input  wire logic [ccrb_pkg::DATA_W-1:0]           S_AXI_WDATA,
   input  wire logic [ccrb_pkg::STRB_W-1:0]           S_AXI_WSTRB,
   input  wire logic                                  S_AXI_WVALID,
   output var  logic                                  S_AXI_WREADY,
   output var  logic [1:0]                            S_AXI_BRESP,
   output var  logic                                  S_AXI_BVALID,
   input  wire logic                                  S_AXI_BREADY,
   input  wire logic [ccrb_pkg::ADDR_W-1:0]           S_AXI_ARADDR,
   input  wire logic                                  S_AXI_ARVALID,
   output var  logic                                  S_AXI_ARREADY,
   output var  logic [ccrb_pkg::DATA_W-1:0]           S_AXI_RDATA,
   output var  logic [1:0]                            S_AXI_RRESP,
   output var  logic                                  S_AXI_RVALID,
   input  wire logic                                  S_AXI_RREADY,
   input  wire logic [ccrb_pkg::PRIV_W-1:0]           CURRENT_PRIVILEGE_LEVEL,
   input  wire logic                                  READ_TIMESTAMP_REQ,
   output var  logic                                  READ_TIMESTAMP_GRANT,
   output var  logic                                  READ_TIMESTAMP_FAULT,
   input  wire logic                                  FAULT_VALID,
   input  wire logic [ccrb_pkg::DATA_W-1:0]           FAULT_LINEAR_ADDRESS,
   output var  logic [ccrb_pkg::PAGE_DIR_BASE_W-1:0]  PAGE_DIRECTORY_BASE,
   output var  logic                                  PAGING_ENABLE,
   output var  logic                                  CACHE_DISABLE,
   output var  logic                                  WRITE_BACK_SELECT,
   output var  logic                                  ALIGNMENT_CHECK_MASK,
   output var  logic                                  WRITE_PROTECT,
   output var  logic                                  PROTECTED_MODE_ENABLE,
   output var  logic                                  TIMESTAMP_PRIVILEGE_LOCK
);

   localparam int DW = ccrb_pkg::DATA_W;
   localparam int AW = ccrb_pkg::ADDR_W;
   localparam int SW = ccrb_pkg::STRB_W;
   localparam int PW = ccrb_pkg::PAGE_DIR_BASE_W;

   // ----------------------------------------------------------------
   // Architectural state
   // ----------------------------------------------------------------
   logic [DW-1:0] system_control;
   logic [DW-1:0] fault_address;
   logic [PW-1:0] page_dir_base;
   logic          ts_lock;
   logic [DW-1:0] next_system_control;
   logic [DW-1:0] next_fault_address;
   logic [PW-1:0] next_page_dir_base;
   logic          next_ts_lock;

   // ----------------------------------------------------------------
   // Write channel state
   // ----------------------------------------------------------------
   ccrb_pkg::ccrb_wr_state_t wr_state;
   ccrb_pkg::ccrb_wr_state_t next_wr_state;
   logic          aw_have;
   logic          w_have;
   logic [AW-1:0] aw_addr;
   logic [DW-1:0] w_data;
   logic [SW-1:0] w_strb;
   logic          next_aw_have;
   logic          next_w_have;
   logic [AW-1:0] next_aw_addr;
   logic [DW-1:0] next_w_data;
   logic [SW-1:0] next_w_strb;
   logic          next_awready;
   logic          next_wready;
   logic          next_bvalid;
   logic [1:0]    next_bresp;
   logic          wr_fire;
   logic          wr_commit;
   logic [DW-1:0] byte_mask;

   // ----------------------------------------------------------------
   // Read channel state
   // ----------------------------------------------------------------
   ccrb_pkg::ccrb_rd_state_t rd_state;
   ccrb_pkg::ccrb_rd_state_t next_rd_state;
   logic          next_arready;
   logic          next_rvalid;
   logic [DW-1:0] next_rdata;
   logic [1:0]    next_rresp;

   // ----------------------------------------------------------------
   // Access check and decode
   // ----------------------------------------------------------------
   logic priv_ok;

   function automatic logic is_mapped(input logic [AW-1:0] addr);
      unique case (addr)
         ccrb_pkg::SYSTEM_CONTROL_OFS,
         ccrb_pkg::SPARE_CONTROL_OFS,
         ccrb_pkg::FAULT_ADDRESS_OFS,
         ccrb_pkg::PAGE_BASE_OFS,
         ccrb_pkg::TIMESTAMP_CONTROL_OFS: is_mapped = 1'b1;
         default:                         is_mapped = 1'b0;
      endcase
   endfunction

   // Reads see the stored fields only, so every bit that has no storage
   // comes back as zero whatever software wrote there.
   function automatic logic [DW-1:0] read_word(input logic [AW-1:0] addr,
                                               input logic [DW-1:0] sys,
                                               input logic [DW-1:0] flt,
                                               input logic [PW-1:0] pdb,
                                               input logic          lock);
      logic [DW-1:0] word;
      word = ccrb_pkg::ZERO_WORD;
      unique case (addr)
         ccrb_pkg::SYSTEM_CONTROL_OFS: word = sys;
         ccrb_pkg::FAULT_ADDRESS_OFS:  word = flt;
         ccrb_pkg::PAGE_BASE_OFS: begin
            word[DW-1:ccrb_pkg::PAGE_DIR_BASE_LSB] = pdb;
         end
         ccrb_pkg::TIMESTAMP_CONTROL_OFS: begin
            word[ccrb_pkg::TS_PRIV_LOCK_BIT] = lock;
         end
         default: word = ccrb_pkg::ZERO_WORD;
      endcase
      read_word = word;
   endfunction

   // In real mode every level may touch the registers; once protection
   // is on, only the most privileged level may.
   always_comb begin
      priv_ok = !system_control[ccrb_pkg::PROTECTED_MODE_ENABLE_BIT] ||
                (CURRENT_PRIVILEGE_LEVEL == ccrb_pkg::MOST_PRIVILEGED);
   end

   // ----------------------------------------------------------------
   // Write channel
   // ----------------------------------------------------------------
   always_comb begin
      next_wr_state = wr_state;
      next_aw_have  = aw_have;
      next_w_have   = w_have;
      next_aw_addr  = aw_addr;
      next_w_data   = w_data;
      next_w_strb   = w_strb;
      next_bvalid   = S_AXI_BVALID;
      next_bresp    = S_AXI_BRESP;
      wr_fire       = 1'b0;
      wr_commit     = 1'b0;
      unique case (wr_state)
         ccrb_pkg::WR_COLLECT: begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
               next_aw_have = 1'b1;
               next_aw_addr = S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
               next_w_have = 1'b1;
               next_w_data = S_AXI_WDATA;
               next_w_strb = S_AXI_WSTRB;
            end
            if (next_aw_have && next_w_have) begin
               wr_fire       = 1'b1;
               next_aw_have  = 1'b0;
               next_w_have   = 1'b0;
               next_bvalid   = 1'b1;
               next_wr_state = ccrb_pkg::WR_RESP;
               if (!is_mapped(next_aw_addr)) begin
                  next_bresp = ccrb_pkg::RESP_DECERR;
               end else if (!priv_ok) begin
                  next_bresp = ccrb_pkg::RESP_SLVERR;
               end else begin
                  next_bresp = ccrb_pkg::RESP_OKAY;
                  wr_commit  = 1'b1;
               end
            end
         end
         ccrb_pkg::WR_RESP: begin
            if (S_AXI_BREADY) begin
               next_bvalid   = 1'b0;
               next_wr_state = ccrb_pkg::WR_COLLECT;
            end
         end
      endcase
      next_awready = (next_wr_state == ccrb_pkg::WR_COLLECT) && !next_aw_have;
      next_wready  = (next_wr_state == ccrb_pkg::WR_COLLECT) && !next_w_have;
   end

   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         wr_state      <= ccrb_pkg::WR_COLLECT;
         aw_have       <= 1'b0;
         w_have        <= 1'b0;
         aw_addr       <= '0;
         w_data        <= '0;
         w_strb        <= '0;
         S_AXI_AWREADY <= 1'b0;
         S_AXI_WREADY  <= 1'b0;
         S_AXI_BVALID  <= 1'b0;
         S_AXI_BRESP   <= ccrb_pkg::RESP_OKAY;
      end else begin
         wr_state      <= next_wr_state;
         aw_have       <= next_aw_have;
         w_have        <= next_w_have;
         aw_addr       <= next_aw_addr;
         w_data        <= next_w_data;
         w_strb        <= next_w_strb;
         S_AXI_AWREADY <= next_awready;
         S_AXI_WREADY  <= next_wready;
         S_AXI_BVALID  <= next_bvalid;
         S_AXI_BRESP   <= next_bresp;
      end
   end

   // ----------------------------------------------------------------
   // Byte lanes
   // ----------------------------------------------------------------
   for (genvar i = 0; i < SW; i++) begin : g_lane
      assign byte_mask[8*i +: 8] = {8{next_w_strb[i]}};
   end

   // ----------------------------------------------------------------
   // Register update
   // ----------------------------------------------------------------
   always_comb begin
      logic [DW-1:0] merged;
      merged = (read_word(next_aw_addr, system_control, fault_address,
                          page_dir_base, ts_lock) & ~byte_mask) |
               (next_w_data & byte_mask);
      next_system_control = system_control;
      next_fault_address  = fault_address;
      next_page_dir_base  = page_dir_base;
      next_ts_lock        = ts_lock;
      if (wr_commit) begin
         unique case (next_aw_addr)
            ccrb_pkg::SYSTEM_CONTROL_OFS: begin
               next_system_control = merged & ccrb_pkg::SYSTEM_CONTROL_MASK;
            end
            ccrb_pkg::FAULT_ADDRESS_OFS: next_fault_address = merged;
            ccrb_pkg::PAGE_BASE_OFS: begin
               next_page_dir_base = merged[DW-1:ccrb_pkg::PAGE_DIR_BASE_LSB];
            end
            ccrb_pkg::TIMESTAMP_CONTROL_OFS: begin
               next_ts_lock = merged[ccrb_pkg::TS_PRIV_LOCK_BIT];
            end
            default: next_system_control = system_control;
         endcase
      end
      // A fault reported by the paging logic outranks a software write in
      // the same cycle, so the faulting address is never lost.
      if (FAULT_VALID) begin
         next_fault_address = FAULT_LINEAR_ADDRESS;
      end
   end

   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         system_control <= ccrb_pkg::SYSTEM_CONTROL_RESET;
         fault_address  <= ccrb_pkg::FAULT_ADDRESS_RESET;
         page_dir_base  <= ccrb_pkg::PAGE_DIR_BASE_RESET;
         ts_lock        <= ccrb_pkg::TS_PRIV_LOCK_RESET;
      end else begin
         system_control <= next_system_control;
         fault_address  <= next_fault_address;
         page_dir_base  <= next_page_dir_base;
         ts_lock        <= next_ts_lock;
      end
   end

   // ----------------------------------------------------------------
   // Read channel
   // ----------------------------------------------------------------
   always_comb begin
      next_rd_state = rd_state;
      next_arready  = S_AXI_ARREADY;
      next_rvalid   = S_AXI_RVALID;
      next_rdata    = S_AXI_RDATA;
      next_rresp    = S_AXI_RRESP;
      unique case (rd_state)
         ccrb_pkg::RD_IDLE: begin
            next_arready = 1'b1;
            if (S_AXI_ARVALID && S_AXI_ARREADY) begin
               next_arready  = 1'b0;
               next_rvalid   = 1'b1;
               next_rd_state = ccrb_pkg::RD_RESP;
               next_rdata    = ccrb_pkg::ZERO_WORD;
               if (!is_mapped(S_AXI_ARADDR)) begin
                  next_rresp = ccrb_pkg::RESP_DECERR;
               end else if (!priv_ok) begin
                  next_rresp = ccrb_pkg::RESP_SLVERR;
               end else begin
                  next_rresp = ccrb_pkg::RESP_OKAY;
                  next_rdata = read_word(S_AXI_ARADDR, system_control,
                                         fault_address, page_dir_base,
                                         ts_lock);
               end
            end
         end
         ccrb_pkg::RD_RESP: begin
            if (S_AXI_RREADY) begin
               next_rvalid   = 1'b0;
               next_arready  = 1'b1;
               next_rd_state = ccrb_pkg::RD_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         rd_state      <= ccrb_pkg::RD_IDLE;
         S_AXI_ARREADY <= 1'b0;
         S_AXI_RVALID  <= 1'b0;
         S_AXI_RDATA   <= ccrb_pkg::ZERO_WORD;
         S_AXI_RRESP   <= ccrb_pkg::RESP_OKAY;
      end else begin
         rd_state      <= next_rd_state;
         S_AXI_ARREADY <= next_arready;
         S_AXI_RVALID  <= next_rvalid;
         S_AXI_RDATA   <= next_rdata;
         S_AXI_RRESP   <= next_rresp;
      end
   end

   // ----------------------------------------------------------------
   // Timestamp read permission
   // ----------------------------------------------------------------
   ccrb_ts_gate u_ts_gate (
      .clk        (SYS_CLK),
      .rst        (RST),
      .lock       (ts_lock),
      .priv_level (CURRENT_PRIVILEGE_LEVEL),
      .req        (READ_TIMESTAMP_REQ),
      .grant      (READ_TIMESTAMP_GRANT),
      .fault      (READ_TIMESTAMP_FAULT)
   );

   // ----------------------------------------------------------------
   // Field outputs, each a stored bit or, for the page directory base, a stored 20-bit field
   // ----------------------------------------------------------------
   assign PAGE_DIRECTORY_BASE   = page_dir_base;
   assign PAGING_ENABLE         = system_control[ccrb_pkg::PAGING_ENABLE_BIT];
   assign CACHE_DISABLE         = system_control[ccrb_pkg::CACHE_DISABLE_BIT];
   assign WRITE_BACK_SELECT     = system_control[ccrb_pkg::WRITE_BACK_SELECT_BIT];
   assign ALIGNMENT_CHECK_MASK  = system_control[ccrb_pkg::ALIGNMENT_CHECK_MASK_BIT];
   assign WRITE_PROTECT         = system_control[ccrb_pkg::WRITE_PROTECT_BIT];
   assign PROTECTED_MODE_ENABLE = system_control[ccrb_pkg::PROTECTED_MODE_ENABLE_BIT];
   assign TIMESTAMP_PRIVILEGE_LOCK = ts_lock;

endmodule

`default_nettype wire

// ==== bench/ccrb_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none

module ccrb_chk (
   input wire logic        SYS_CLK,
   input wire logic        RST,
   input wire logic [7:0]  S_AXI_ARADDR,
   input wire logic        S_AXI_ARVALID,
   input wire logic        S_AXI_ARREADY,
   input wire logic [31:0] S_AXI_RDATA,
   input wire logic [1:0]  S_AXI_RRESP,
   input wire logic        S_AXI_RVALID,
   input wire logic        S_AXI_BVALID,
   input wire logic [1:0]  CURRENT_PRIVILEGE_LEVEL,
   input wire logic        READ_TIMESTAMP_REQ,
   input wire logic        READ_TIMESTAMP_GRANT,
   input wire logic        READ_TIMESTAMP_FAULT,
   input wire logic [19:0] PAGE_DIRECTORY_BASE,
   input wire logic        TIMESTAMP_PRIVILEGE_LOCK
);
   // ----------------------------------------------------------------
   // Address of the read in flight
   // ----------------------------------------------------------------
   logic [7:0] last_ar;
   logic [7:0] next_last_ar;

   always_comb begin
      next_last_ar = (S_AXI_ARVALID && S_AXI_ARREADY) ? S_AXI_ARADDR : last_ar;
   end

   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         last_ar <= 8'h00;
      end else begin
         last_ar <= next_last_ar;
      end
   end

   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (RST);

   sequence s_ts_locked;
      READ_TIMESTAMP_REQ && TIMESTAMP_PRIVILEGE_LOCK && CURRENT_PRIVILEGE_LEVEL != 2'h0;
   endsequence
   sequence s_ts_free;
      READ_TIMESTAMP_REQ && (!TIMESTAMP_PRIVILEGE_LOCK || CURRENT_PRIVILEGE_LEVEL == 2'h0);
   endsequence
   sequence s_rd_from(logic [7:0] a);
      $rose(S_AXI_RVALID) && last_ar == a;
   endsequence

   a_lock_deny: assert property (s_ts_locked |=> READ_TIMESTAMP_FAULT && !READ_TIMESTAMP_GRANT)
      else $error("timestamp read not refused");
   a_free_grant: assert property (s_ts_free |=> READ_TIMESTAMP_GRANT && !READ_TIMESTAMP_FAULT)
      else $error("timestamp read not granted");
   a_idle_quiet: assert property (!READ_TIMESTAMP_REQ |=> !READ_TIMESTAMP_GRANT && !READ_TIMESTAMP_FAULT)
      else $error("timestamp answer without request");
   a_lock_reset: assert property (disable iff (1'b0) RST |-> TIMESTAMP_PRIVILEGE_LOCK)
      else $error("lock bit not set in reset");
   a_ts_rsvd_zero: assert property (s_rd_from(8'h10) |-> (S_AXI_RDATA & 32'hfffffffb) == 32'h0)
      else $error("reserved timestamp bits not zero");
   a_pb_low_zero: assert property (s_rd_from(8'h0c) |-> S_AXI_RDATA[11:0] == 12'h000)
      else $error("page base low bits not zero");
   a_deny_data: assert property (S_AXI_RVALID && S_AXI_RRESP == 2'h2 |-> S_AXI_RDATA == 32'h0)
      else $error("refused read returned data");
   a_pdb_commit: assert property (!$stable(PAGE_DIRECTORY_BASE) |-> $rose(S_AXI_BVALID))
      else $error("page base moved without a write");
   a_lock_commit: assert property (!$stable(TIMESTAMP_PRIVILEGE_LOCK) |-> $rose(S_AXI_BVALID))
      else $error("lock bit moved without a write");
   a_rd_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
      else $error("read answer late");
endmodule

`default_nettype wire

// ==== bench/cpu_control_register_bank_tb.sv ====
`timescale 1ns/1ps
`default_nettype none

module cpu_control_register_bank_tb;
   localparam logic [1:0] OK = ccrb_pkg::RESP_OKAY;
   localparam logic [1:0] SE = ccrb_pkg::RESP_SLVERR;
   localparam logic [1:0] DE = ccrb_pkg::RESP_DECERR;
   localparam logic [7:0] TS = ccrb_pkg::TIMESTAMP_CONTROL_OFS;
   localparam logic [7:0] PB = ccrb_pkg::PAGE_BASE_OFS;
   logic        clk = 1'b0, rst = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic [3:0]  wstrb = 4'hf;
   wire logic [5:0] sc;
   logic        arvalid = 1'b0, rready = 1'b0, req = 1'b0, fvalid = 1'b0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, faddr = 32'h0, seed = 32'hc825, rdata;
   logic [1:0]  level = 2'h0, bresp, rresp;
   logic        awready, wready, bvalid, arready, rvalid, grant, fault;
   logic [19:0] pdb;
   logic [33:0] rq[$];
   logic [1:0]  bq[$], tq[$];
   int          error_cnt = 0, checks_done = 0, cyc = 0;

   always #4 clk = ~clk;

   ccrb_regs dut (.SYS_CLK(clk), .RST(rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
      .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
      .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
      .CURRENT_PRIVILEGE_LEVEL(level), .READ_TIMESTAMP_REQ(req), .READ_TIMESTAMP_GRANT(grant),
      .READ_TIMESTAMP_FAULT(fault), .FAULT_VALID(fvalid), .FAULT_LINEAR_ADDRESS(faddr),
      .PAGE_DIRECTORY_BASE(pdb), .PAGING_ENABLE(sc[5]), .CACHE_DISABLE(sc[4]),
      .WRITE_BACK_SELECT(sc[3]), .ALIGNMENT_CHECK_MASK(sc[2]), .WRITE_PROTECT(sc[1]),
      .PROTECTED_MODE_ENABLE(sc[0]), .TIMESTAMP_PRIVILEGE_LOCK());

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      x = x ^ (x << 5);
      return x;
   endfunction

   task automatic check(input logic [33:0] seen, input logic [33:0] exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic final_report();
      error_cnt += rq.size() + bq.size() + tq.size();
      if (error_cnt == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // Each task waits an edge first so no strobe is assigned twice in one step.
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
      bq.push_back(e);
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever begin
         @(posedge clk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
         if (bvalid === 1'b1) break;
      end
      bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [33:0] e);
      rq.push_back(e);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever begin
         @(posedge clk);
         if (arready === 1'b1) arvalid <= 1'b0;
         if (rvalid === 1'b1) break;
      end
      rready <= 1'b0;
   endtask

   task automatic ts(input logic [1:0] l, input logic [1:0] e);
      tq.push_back(e);
      @(posedge clk);
      level <= l;
      req <= 1'b1;
      @(posedge clk);
      req <= 1'b0;
   endtask

   // ----------------------------------------------------------------
   // Result watcher and timeout
   // ----------------------------------------------------------------
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (rvalid === 1'b1 && rready) check({rresp, rdata}, rq.pop_front());
      if (bvalid === 1'b1 && bready) check({32'h0, bresp}, {32'h0, bq.pop_front()});
      if (grant !== 1'b0 || fault !== 1'b0) check({32'h0, grant, fault}, {32'h0, tq.pop_front()});
      if (cyc == 20000) begin
         error_cnt++;
         final_report();
      end
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      // Raising reset at time zero gives the asynchronous resets an edge to act on.
      rst <= 1'b1;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      rd(TS, {OK, 32'h4});
      rd(PB, {OK, 32'h0});
      for (int i = 0; i < 4; i++) ts(i[1:0], (i == 0) ? 2'b10 : 2'b01);
      seed = xs(seed);
      wr(TS, seed & 32'hfffffffb, OK);
      rd(TS, {OK, 32'h0});
      for (int i = 0; i < 4; i++) ts(i[1:0], 2'b10);
      wr(TS, 32'hffffffff, OK);
      rd(TS, {OK, 32'h4});
      seed = xs(seed);
      wr(PB, seed & 32'hfffff000, OK);
      rd(PB, {OK, seed & 32'hfffff000});
      check({14'h0, pdb}, {14'h0, seed[31:12]});
      @(posedge clk);
      faddr <= xs(seed);
      fvalid <= 1'b1;
      @(posedge clk);
      fvalid <= 1'b0;
      rd(ccrb_pkg::FAULT_ADDRESS_OFS, {OK, xs(seed)});
      wr(8'h14, seed, DE);
      rd(8'h14, {DE, 32'h0});
      wr(ccrb_pkg::SYSTEM_CONTROL_OFS, 32'hfffffffe, OK);
      rd(ccrb_pkg::SYSTEM_CONTROL_OFS, {OK, ccrb_pkg::SYSTEM_CONTROL_MASK & 32'hfffffffe});
      check({28'h0, sc}, {28'h0, 6'h3e});
      wr(ccrb_pkg::SYSTEM_CONTROL_OFS, 32'h1, OK);
      check({28'h0, sc}, {28'h0, 6'h01});
      @(posedge clk);
      level <= 2'h2;
      wr(PB, 32'hfffff000, SE);
      rd(PB, {SE, 32'h0});
      @(posedge clk);
      level <= 2'h0;
      rd(PB, {OK, seed & 32'hfffff000});
      wstrb <= 4'h8;
      wr(PB, 32'h0, OK);
      rd(PB, {OK, seed & 32'h00fff000});
      repeat (4) @(posedge clk);
      final_report();
   end
endmodule

bind ccrb_regs ccrb_chk chk (.SYS_CLK(SYS_CLK), .RST(RST), .S_AXI_ARADDR(S_AXI_ARADDR),
   .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
   .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_BVALID(S_AXI_BVALID),
   .CURRENT_PRIVILEGE_LEVEL(CURRENT_PRIVILEGE_LEVEL), .READ_TIMESTAMP_REQ(READ_TIMESTAMP_REQ),
   .READ_TIMESTAMP_GRANT(READ_TIMESTAMP_GRANT), .READ_TIMESTAMP_FAULT(READ_TIMESTAMP_FAULT),
   .PAGE_DIRECTORY_BASE(PAGE_DIRECTORY_BASE), .TIMESTAMP_PRIVILEGE_LOCK(TIMESTAMP_PRIVILEGE_LOCK));

`default_nettype wire
